// *** src/dic_regs.svh ***
// register offsets, source bit positions and reset values of the interrupt controller
`ifndef DIC_REGS_SVH
`define DIC_REGS_SVH

// ============================================================
// register offsets (byte addresses)
`define DIC_ADDR_W 12
`define DIC_OFF_IRQ_STATUS 12'h180
`define DIC_OFF_IRQ_RAW 12'h184
`define DIC_OFF_IRQ_ENABLE 12'h188
`define DIC_OFF_IRQ_ENCLR 12'h18C
`define DIC_OFF_IRQ_SOFT 12'h190
`define DIC_OFF_FIQ_STATUS 12'h280
`define DIC_OFF_FIQ_RAW 12'h284
`define DIC_OFF_FIQ_ENABLE 12'h288
`define DIC_OFF_FIQ_ENCLR 12'h28C
`define DIC_OFF_FIQ_SOFT 12'h290
`define DIC_OFF_DB_MASK 12'h154
`define DIC_OFF_DOORBELL 12'h158
`define DIC_OFF_TMR1_CLR 12'h30C
`define DIC_OFF_TMR2_CLR 12'h32C
`define DIC_OFF_TMR3_CLR 12'h34C
`define DIC_OFF_TMR4_CLR 12'h36C

// ============================================================
// source bit positions
`define DIC_BIT_SOFT 1
`define DIC_BIT_CON_RX 2
`define DIC_BIT_CON_TX 3
`define DIC_BIT_TMR 4
`define DIC_BIT_EXT 8
`define DIC_BIT_XCS 12
`define DIC_BIT_DOOR 15
`define DIC_BIT_DMA 16
`define DIC_BIT_PCI_IRQ 18
`define DIC_BIT_POWER_MGMT_CTL_STATUS 19
`define DIC_BIT_BUILT_IN_SELF_TEST_REG 22
`define DIC_BIT_SERR 23
`define DIC_BIT_SDRAM 24
`define DIC_BIT_POST 25
`define DIC_BIT_DISCARD 27
`define DIC_BIT_PCI_ERR 28
`define DIC_BUILT_IN_SELF_TEST_REG_START_BIT 6

// ============================================================
// reset values and fixed patterns
`define DIC_RESERVED_MASK 32'h0430_0001
`define DIC_ZERO32 32'h0000_0000
`endif

// *** src/dic_pkg.sv ***
// types shared by the dual interrupt controller
package dic_pkg;
   typedef logic [31:0] dic_word_t;
   typedef struct packed {
      dic_word_t raw;
      dic_word_t irq_en;
      dic_word_t fiq_en;
      dic_word_t irq_stat;
      dic_word_t fiq_stat;
      dic_word_t rdata;
      logic irq_n;
      logic fiq_n;
   } dic_state_t;
endpackage

// *** src/dic_top.sv ***
// dual (normal and fast) interrupt controller with shared raw source vector
//
// Behaviour
// - raw bits 4-7 follow timers one to four; any write to timer clear clears.
// - bits 8-11 external inputs, 12-14 chip selects, 18 PCI line; cleared at source.
// - bit 15 host doorbell; cleared by writing doorbell mask or doorbell register.
// - bits 16,17 DMA channels; cleared by write-one flag in DMA control.
// - bit 19 set by host power-management write, cleared by local write.
// - bit 22 self-test start; cleared by writing zero to self-test bit 6.
// - bits 23,24,27 cleared by write-one flags in processor control register.
// - bit 25 stays active until all inbound posted entries are retired.
// - bits 28-31 PCI errors; cleared by write-one flags in PCI status.
// - masked status reads raw AND that controller's enable mask; read-only.
// - each active-low request is the NOR of its 32 masked status bits.
// - both raw status registers read the same vector; neither is writable.
// - enable masks read-only, reset to zero, changed only by set/clear writes.
// - enable-set write sets mask bits whose data bit is one.
// - enable-clear write clears mask bits whose data bit is one; not readable.
// - soft write loads data bit 1 into raw bit 1, ignores others.
// - no priority; each source enabled independently for normal and fast.
// - all sources level-sensitive, held until cleared at their source.
// - reserved positions 0, 20, 21, 26 read zero; software writes zero.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "dic_regs.svh"

module dic_top
   import dic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [`DIC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // level sources, active high unless named _n
   input wire logic console_rx_irq,
   input wire logic console_tx_irq,
   input wire logic [3:0] ext_irq_n,
   input wire logic [2:0] xbus_cs_n,
   input wire logic pci_irq_n,
   input wire logic inbound_post_pending,
   // event pulses that set sticky sources
   input wire logic [3:0] timer_expire,
   input wire logic host_doorbell_event,
   input wire logic [1:0] dma_done,
   input wire logic host_power_mgmt_ctl_status_write,
   input wire logic built_in_self_test_reg_start_request,
   input wire logic [2:0] ctl_error_event,
   input wire logic [3:0] pci_error_event,
   // clear strobes from the owning registers
   input wire logic [1:0] dma_flag_clear,
   input wire logic local_power_mgmt_ctl_status_write,
   input wire logic built_in_self_test_reg_reg_write,
   input wire logic built_in_self_test_reg_wdata_start,
   input wire logic [2:0] ctl_flag_clear,
   input wire logic [3:0] pci_flag_clear,
   // requests to the processor core
   output logic normal_request_n,
   output logic fast_request_n
);

   // ============================================================
   // helpers

   // sticky flag update: a set in the clear cycle wins
   function automatic logic sticky(input logic q, input logic set, input logic clr);
      sticky = set | (q & ~clr);
   endfunction

   function automatic logic hit(input logic [`DIC_ADDR_W-1:0] a,
                                input logic [`DIC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // ============================================================
   // state

   dic_state_t s;
   dic_state_t next_s;

   logic wr_tmr [4];
   logic wr_door;

   always_comb begin
      wr_tmr[0] = reg_wr && hit(reg_addr, `DIC_OFF_TMR1_CLR);
      wr_tmr[1] = reg_wr && hit(reg_addr, `DIC_OFF_TMR2_CLR);
      wr_tmr[2] = reg_wr && hit(reg_addr, `DIC_OFF_TMR3_CLR);
      wr_tmr[3] = reg_wr && hit(reg_addr, `DIC_OFF_TMR4_CLR);
      wr_door = reg_wr && (hit(reg_addr, `DIC_OFF_DB_MASK) ||
                           hit(reg_addr, `DIC_OFF_DOORBELL));
   end

   always_comb begin
      next_s = s;

      // soft source: both soft locations drive the one shared raw bit
      if (reg_wr && (hit(reg_addr, `DIC_OFF_IRQ_SOFT) ||
                     hit(reg_addr, `DIC_OFF_FIQ_SOFT))) begin
         next_s.raw[`DIC_BIT_SOFT] = reg_wdata[`DIC_BIT_SOFT];
      end

      // level sources are resampled every cycle
      next_s.raw[`DIC_BIT_CON_RX] = console_rx_irq;
      next_s.raw[`DIC_BIT_CON_TX] = console_tx_irq;
      next_s.raw[`DIC_BIT_EXT +: 4] = ~ext_irq_n;
      next_s.raw[`DIC_BIT_XCS +: 3] = ~xbus_cs_n;
      next_s.raw[`DIC_BIT_PCI_IRQ] = ~pci_irq_n;
      next_s.raw[`DIC_BIT_POST] = inbound_post_pending;

      // timers: any data written to the clear location clears
      for (int i = 0; i < 4; i++) begin
         next_s.raw[`DIC_BIT_TMR + i] =
            sticky(s.raw[`DIC_BIT_TMR + i], timer_expire[i], wr_tmr[i]);
      end

      next_s.raw[`DIC_BIT_DOOR] =
         sticky(s.raw[`DIC_BIT_DOOR], host_doorbell_event, wr_door);

      for (int i = 0; i < 2; i++) begin
         next_s.raw[`DIC_BIT_DMA + i] =
            sticky(s.raw[`DIC_BIT_DMA + i], dma_done[i], dma_flag_clear[i]);
      end

      next_s.raw[`DIC_BIT_POWER_MGMT_CTL_STATUS] =
         sticky(s.raw[`DIC_BIT_POWER_MGMT_CTL_STATUS], host_power_mgmt_ctl_status_write, local_power_mgmt_ctl_status_write);

      next_s.raw[`DIC_BIT_BUILT_IN_SELF_TEST_REG] =
         sticky(s.raw[`DIC_BIT_BUILT_IN_SELF_TEST_REG], built_in_self_test_reg_start_request,
                built_in_self_test_reg_reg_write && !built_in_self_test_reg_wdata_start);

      next_s.raw[`DIC_BIT_SERR] =
         sticky(s.raw[`DIC_BIT_SERR], ctl_error_event[0], ctl_flag_clear[0]);
      next_s.raw[`DIC_BIT_SDRAM] =
         sticky(s.raw[`DIC_BIT_SDRAM], ctl_error_event[1], ctl_flag_clear[1]);
      next_s.raw[`DIC_BIT_DISCARD] =
         sticky(s.raw[`DIC_BIT_DISCARD], ctl_error_event[2], ctl_flag_clear[2]);

      for (int i = 0; i < 4; i++) begin
         next_s.raw[`DIC_BIT_PCI_ERR + i] =
            sticky(s.raw[`DIC_BIT_PCI_ERR + i], pci_error_event[i], pci_flag_clear[i]);
      end

      // reserved positions never set
      next_s.raw = next_s.raw & ~`DIC_RESERVED_MASK;

      // enable masks: one write per cycle, so arrival order decides
      if (reg_wr) begin
         case (reg_addr)
            `DIC_OFF_IRQ_ENABLE: next_s.irq_en = s.irq_en | reg_wdata;
            `DIC_OFF_IRQ_ENCLR: next_s.irq_en = s.irq_en & ~reg_wdata;
            `DIC_OFF_FIQ_ENABLE: next_s.fiq_en = s.fiq_en | reg_wdata;
            `DIC_OFF_FIQ_ENCLR: next_s.fiq_en = s.fiq_en & ~reg_wdata;
            default: begin
            end
         endcase
      end

      // status and requests from the next values: one clock behind the cause
      next_s.irq_stat = next_s.raw & next_s.irq_en;
      next_s.fiq_stat = next_s.raw & next_s.fiq_en;
      next_s.irq_n = ~|next_s.irq_stat;
      next_s.fiq_n = ~|next_s.fiq_stat;

      // read data stand only in the cycle after the strobe
      next_s.rdata = `DIC_ZERO32;
      if (reg_rd) begin
         case (reg_addr)
            `DIC_OFF_IRQ_STATUS: next_s.rdata = s.irq_stat;
            `DIC_OFF_FIQ_STATUS: next_s.rdata = s.fiq_stat;
            `DIC_OFF_IRQ_RAW: next_s.rdata = s.raw;
            `DIC_OFF_FIQ_RAW: next_s.rdata = s.raw;
            `DIC_OFF_IRQ_ENABLE: next_s.rdata = s.irq_en;
            `DIC_OFF_FIQ_ENABLE: next_s.rdata = s.fiq_en;
            // write-only and unmapped locations read as zero
            default: next_s.rdata = `DIC_ZERO32;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s.raw <= `DIC_ZERO32;
         s.irq_en <= `DIC_ZERO32;
         s.fiq_en <= `DIC_ZERO32;
         s.irq_stat <= `DIC_ZERO32;
         s.fiq_stat <= `DIC_ZERO32;
         s.rdata <= `DIC_ZERO32;
         s.irq_n <= 1'b1;
         s.fiq_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign normal_request_n = s.irq_n;
   assign fast_request_n = s.fiq_n;

   // ============================================================
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_irq_set_wr;
      reg_wr && reg_addr == `DIC_OFF_IRQ_ENABLE;
   endsequence

   sequence s_fiq_clr_wr;
      reg_wr && reg_addr == `DIC_OFF_FIQ_ENCLR;
   endsequence

   sequence s_tmr1_clr_quiet;
      wr_tmr[0] && !timer_expire[0];
   endsequence

   sequence s_raw_rd;
      reg_rd && (reg_addr == `DIC_OFF_IRQ_RAW || reg_addr == `DIC_OFF_FIQ_RAW);
   endsequence

   sequence s_soft_wr;
      reg_wr && (reg_addr == `DIC_OFF_IRQ_SOFT || reg_addr == `DIC_OFF_FIQ_SOFT);
   endsequence

   sequence s_fiq_set_wr;
      reg_wr && reg_addr == `DIC_OFF_FIQ_ENABLE;
   endsequence

   sequence s_irq_clr_wr;
      reg_wr && reg_addr == `DIC_OFF_IRQ_ENCLR;
   endsequence

   AST_TMR_CLEAR: assert property (s_tmr1_clr_quiet |=> !s.raw[`DIC_BIT_TMR])
      else $error("timer one source not cleared by clear write");

   AST_TMR_SET: assert property (timer_expire[3] |=> s.raw[`DIC_BIT_TMR + 3])
      else $error("timer four event lost");

   AST_EXT_LEVEL: assert property ($fell(ext_irq_n[2]) |=> s.raw[`DIC_BIT_EXT + 2])
      else $error("external input not reflected in raw status");

   AST_DOOR: assert property (wr_door && !host_doorbell_event |=> !s.raw[`DIC_BIT_DOOR])
      else $error("doorbell source survived mask write");

   AST_DMA_HOLD: assert property (
      s.raw[`DIC_BIT_DMA] && !dma_flag_clear[0] |=> s.raw[`DIC_BIT_DMA])
      else $error("dma source dropped without clear");

   AST_POWER_MGMT_CTL_STATUS: assert property (
      host_power_mgmt_ctl_status_write ##1 (!local_power_mgmt_ctl_status_write)[*2] |=> s.raw[`DIC_BIT_POWER_MGMT_CTL_STATUS])
      else $error("power management source not held");

   AST_BUILT_IN_SELF_TEST_REG: assert property (
      built_in_self_test_reg_reg_write && built_in_self_test_reg_wdata_start && !s.raw[`DIC_BIT_BUILT_IN_SELF_TEST_REG] && !built_in_self_test_reg_start_request
      |=> !s.raw[`DIC_BIT_BUILT_IN_SELF_TEST_REG])
      else $error("self-test source set by a write of one");

   AST_SERR_CLR: assert property (
      ctl_flag_clear[0] && !ctl_error_event[0] |=> !s.raw[`DIC_BIT_SERR])
      else $error("system error source not cleared");

   AST_POST: assert property (inbound_post_pending |=> s.raw[`DIC_BIT_POST])
      else $error("posted list source not active");

   AST_PCI_ERR: assert property (pci_error_event[1] && pci_flag_clear[1]
      |=> s.raw[`DIC_BIT_PCI_ERR + 1])
      else $error("pci error lost when set met clear");

   AST_STATUS_AND: assert property (
      s.irq_stat == (s.raw & s.irq_en) && s.fiq_stat == (s.raw & s.fiq_en))
      else $error("masked status differs from raw and enable");

   AST_NOR: assert property (
      normal_request_n == (s.irq_stat == `DIC_ZERO32) &&
      fast_request_n == (s.fiq_stat == `DIC_ZERO32))
      else $error("request line not the nor of masked status");

   AST_RAW_READ: assert property (s_raw_rd |=> reg_rdata == $past(s.raw))
      else $error("raw status read returned wrong data");

   AST_MASK_HOLD: assert property (
      !reg_wr |=> s.irq_en == $past(s.irq_en) && s.fiq_en == $past(s.fiq_en))
      else $error("enable mask changed without a write");

   AST_SET: assert property (s_irq_set_wr |=>
      s.irq_en == ($past(s.irq_en) | $past(reg_wdata)))
      else $error("enable set write wrong");

   AST_CLR: assert property (s_fiq_clr_wr |=>
      s.fiq_en == ($past(s.fiq_en) & ~$past(reg_wdata)))
      else $error("enable clear write wrong");

   AST_SOFT: assert property (s_soft_wr |=>
      s.raw[`DIC_BIT_SOFT] == $past(reg_wdata[`DIC_BIT_SOFT]))
      else $error("soft source not loaded from data bit 1");

   AST_RSV: assert property ((s.raw & `DIC_RESERVED_MASK) == `DIC_ZERO32)
      else $error("reserved raw bit set");

   AST_FOLLOW: assert property (
      s_irq_set_wr ##0 ((next_s.raw & reg_wdata) != `DIC_ZERO32) |=> !normal_request_n)
      else $error("request did not follow mask change");

   AST_REQ_FOLLOW: assert property (
      reg_wr && reg_addr == `DIC_OFF_FIQ_ENABLE && ((next_s.raw & reg_wdata) != `DIC_ZERO32)
      |=> !fast_request_n)
      else $error("fast request not asserted one clock after enable");

   // checked while reset is high, so it opts out of the default disable
   AST_RESET_STATE: assert property (disable iff (1'b0)
      reset |=> s.irq_en == `DIC_ZERO32 && s.fiq_en == `DIC_ZERO32 && s.raw == `DIC_ZERO32
      && normal_request_n && fast_request_n && reg_rdata == `DIC_ZERO32)
      else $error("state not cleared by reset");

   AST_CONSOLE: assert property (1'b1 |=>
      s.raw[`DIC_BIT_CON_RX +: 2] == $past({console_tx_irq, console_rx_irq}))
      else $error("console source not followed as a level");

   AST_XCS_LEVEL: assert property (
      1'b1 |=> s.raw[`DIC_BIT_XCS +: 3] == ~$past(xbus_cs_n))
      else $error("chip-select source not followed as a level");

   AST_PCI_LINE: assert property (
      1'b1 |=> s.raw[`DIC_BIT_PCI_IRQ] == !$past(pci_irq_n))
      else $error("pci line not followed as a level");

   AST_POST_DROP: assert property (!inbound_post_pending |=> !s.raw[`DIC_BIT_POST])
      else $error("posted list source held after last entry retired");

   AST_DOOR_SET: assert property (host_doorbell_event |=> s.raw[`DIC_BIT_DOOR])
      else $error("doorbell event lost");

   AST_DMA_CLR: assert property (
      dma_flag_clear[1] && !dma_done[1] |=> !s.raw[`DIC_BIT_DMA + 1])
      else $error("dma channel two source not cleared");

   AST_POWER_MGMT_CTL_STATUS_CLR: assert property (
      local_power_mgmt_ctl_status_write && !host_power_mgmt_ctl_status_write |=> !s.raw[`DIC_BIT_POWER_MGMT_CTL_STATUS])
      else $error("power management source not cleared by local write");

   AST_BUILT_IN_SELF_TEST_REG_CLR: assert property (
      built_in_self_test_reg_reg_write && !built_in_self_test_reg_wdata_start && !built_in_self_test_reg_start_request |=> !s.raw[`DIC_BIT_BUILT_IN_SELF_TEST_REG])
      else $error("self-test source not cleared by a write of zero");

   AST_DISCARD: assert property (ctl_error_event[2] |=> s.raw[`DIC_BIT_DISCARD])
      else $error("discard timer event lost");

   AST_PCI_ERR_CLR: assert property (
      pci_flag_clear[3] && !pci_error_event[3] |=> !s.raw[`DIC_BIT_PCI_ERR + 3])
      else $error("pci error source not cleared");

   AST_STAT_READ: assert property (
      reg_rd && reg_addr == `DIC_OFF_IRQ_STATUS |=> reg_rdata == $past(s.raw & s.irq_en))
      else $error("normal masked status read wrong");

   AST_MASK_READ: assert property (
      reg_rd && reg_addr == `DIC_OFF_FIQ_ENABLE |=> reg_rdata == $past(s.fiq_en))
      else $error("fast enable mask read wrong");

   AST_WO_READ: assert property (
      reg_rd && (reg_addr == `DIC_OFF_IRQ_ENCLR || reg_addr == `DIC_OFF_FIQ_ENCLR)
      |=> reg_rdata == `DIC_ZERO32)
      else $error("enable clear location returned data");

   AST_FIQ_SET: assert property (s_fiq_set_wr |=>
      s.fiq_en == ($past(s.fiq_en) | $past(reg_wdata)))
      else $error("fast enable set write wrong");

   AST_IRQ_CLR: assert property (s_irq_clr_wr |=>
      s.irq_en == ($past(s.irq_en) & ~$past(reg_wdata)))
      else $error("normal enable clear write wrong");

   AST_SOFT_KEEP: assert property (
      !(reg_wr && (reg_addr == `DIC_OFF_IRQ_SOFT || reg_addr == `DIC_OFF_FIQ_SOFT))
      |=> s.raw[`DIC_BIT_SOFT] == $past(s.raw[`DIC_BIT_SOFT]))
      else $error("soft source changed without a soft write");

endmodule
`default_nettype wire

// *** testbench/dic_core_model.sv ***
// behavioural processor core that takes the normal and fast requests
`timescale 1ns/1ns
`default_nettype none

module dic_core_model
   import dic_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // requests from the controller
   input wire logic normal_request_n,
   input wire logic fast_request_n,
   // requests taken so far
   output logic [7:0] irq_taken,
   output logic [7:0] fiq_taken
);
   logic irq_prev;
   logic fiq_prev;

   // ====================
   // entry on each falling edge; the line alone cannot name the source
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_prev <= 1'b1;
         fiq_prev <= 1'b1;
         irq_taken <= 8'h00;
         fiq_taken <= 8'h00;
      end else begin
         irq_prev <= normal_request_n;
         fiq_prev <= fast_request_n;
         if (irq_prev && !normal_request_n) begin
            irq_taken <= irq_taken + 8'h01;
         end
         if (fiq_prev && !fast_request_n) begin
            fiq_taken <= fiq_taken + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/dic_top_tb.sv ***
// self-checking testbench of the dual interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "dic_regs.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; \
   $display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module dic_top_tb
   import dic_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr, reg_rd, console_rx_irq, console_tx_irq, pci_irq_n, inbound_post_pending;
   logic host_doorbell_event, host_power_mgmt_ctl_status_write, built_in_self_test_reg_start_request, local_power_mgmt_ctl_status_write;
   logic built_in_self_test_reg_reg_write, built_in_self_test_reg_wdata_start, normal_request_n, fast_request_n;
   logic [11:0] reg_addr;
   logic [3:0] ext_irq_n, timer_expire, pci_error_event, pci_flag_clear;
   logic [2:0] xbus_cs_n, ctl_error_event, ctl_flag_clear;
   logic [1:0] dma_done, dma_flag_clear;
   logic [7:0] irq_taken, fiq_taken;
   dic_word_t reg_wdata, reg_rdata, exp_raw, irq_m, fiq_m;
   int n_errors = 0;
   int check_count = 0;
   int sb[9] = '{16, 17, 23, 24, 27, 28, 29, 30, 31};

   dic_top uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .console_rx_irq(console_rx_irq), .console_tx_irq(console_tx_irq),
      .ext_irq_n(ext_irq_n), .xbus_cs_n(xbus_cs_n), .pci_irq_n(pci_irq_n),
      .inbound_post_pending(inbound_post_pending), .timer_expire(timer_expire),
      .host_doorbell_event(host_doorbell_event), .dma_done(dma_done),
      .host_power_mgmt_ctl_status_write(host_power_mgmt_ctl_status_write), .built_in_self_test_reg_start_request(built_in_self_test_reg_start_request),
      .ctl_error_event(ctl_error_event), .pci_error_event(pci_error_event),
      .dma_flag_clear(dma_flag_clear), .local_power_mgmt_ctl_status_write(local_power_mgmt_ctl_status_write),
      .built_in_self_test_reg_reg_write(built_in_self_test_reg_reg_write), .built_in_self_test_reg_wdata_start(built_in_self_test_reg_wdata_start),
      .ctl_flag_clear(ctl_flag_clear), .pci_flag_clear(pci_flag_clear),
      .normal_request_n(normal_request_n), .fast_request_n(fast_request_n));

   dic_core_model core (.clk(clk), .reset(reset), .normal_request_n(normal_request_n),
      .fast_request_n(fast_request_n), .irq_taken(irq_taken), .fiq_taken(fiq_taken));

   always #2 clk = ~clk;

   // ====================
   // register port: strobes change just after an edge, one cycle long
   task automatic wr(input logic [11:0] a, input dic_word_t d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input dic_word_t ex);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("read data", ex, reg_rdata)
   endtask

   task automatic check_all;
      rd(`DIC_OFF_IRQ_RAW, exp_raw);
      rd(`DIC_OFF_FIQ_RAW, exp_raw);
      rd(`DIC_OFF_IRQ_STATUS, exp_raw & irq_m);
      rd(`DIC_OFF_FIQ_STATUS, exp_raw & fiq_m);
      rd(`DIC_OFF_IRQ_ENABLE, irq_m);
      rd(`DIC_OFF_FIQ_ENABLE, fiq_m);
      `CHK("normal_request_n", ~|(exp_raw & irq_m), normal_request_n)
      `CHK("fast_request_n", ~|(exp_raw & fiq_m), fast_request_n)
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ====================
   // watchdog at 10000 cycles, well beyond the fewer than one thousand cycles the tests need
   initial begin
      #40000;
      n_errors++;
      complete_run();
   end

   // ====================
   initial begin
      {reg_wr, reg_rd, console_rx_irq, console_tx_irq, inbound_post_pending} = 5'h00;
      {host_doorbell_event, host_power_mgmt_ctl_status_write, built_in_self_test_reg_start_request} = 3'h0;
      {local_power_mgmt_ctl_status_write, built_in_self_test_reg_reg_write, built_in_self_test_reg_wdata_start} = 3'h0;
      {pci_irq_n, ext_irq_n, xbus_cs_n} = 8'hFF;
      {timer_expire, pci_error_event, pci_flag_clear} = 12'h000;
      {ctl_error_event, ctl_flag_clear, dma_done, dma_flag_clear} = 10'h000;
      reg_addr = 12'h000;
      reg_wdata = 32'h0000_0000;
      exp_raw = 32'h0000_0000;
      irq_m = 32'h0000_0000;
      fiq_m = 32'h0000_0000;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      check_all();
      // level sources while masks are still zero, then one mask bit
      for (int j = 0; j < 8; j++) begin
         @(posedge clk);
         {pci_irq_n, xbus_cs_n, ext_irq_n} <= ~(8'h01 << j);
         exp_raw[(j == 7) ? 18 : 8 + j] = 1'b1;
         check_all();
         @(posedge clk);
         {pci_irq_n, xbus_cs_n, ext_irq_n} <= 8'hFF;
         exp_raw = 32'h0000_0000;
         check_all();
      end
      @(posedge clk);
      console_rx_irq <= 1'b1;
      exp_raw[2] = 1'b1;
      check_all();
      wr(`DIC_OFF_IRQ_ENABLE, 32'h0000_0004);
      #1;
      `CHK("normal_request_n", 1'b0, normal_request_n)
      // set then clear, one idle cycle apart: the later write wins
      wr(`DIC_OFF_FIQ_ENABLE, 32'h0000_0004);
      wr(`DIC_OFF_FIQ_ENCLR, 32'h0000_0004);
      irq_m = 32'h0000_0004;
      check_all();
      wr(`DIC_OFF_IRQ_ENABLE, 32'hFBCF_FFFE);
      wr(`DIC_OFF_FIQ_ENABLE, 32'h5A0F_A0F0);
      wr(`DIC_OFF_IRQ_ENCLR, 32'h0000_0014);
      irq_m = 32'hFBCF_FFEA;
      fiq_m = 32'h5A0F_A0F0;
      check_all();
      // read-only locations ignore writes; write-only and unmapped read zero
      wr(`DIC_OFF_IRQ_RAW, 32'hFFFF_FFFF);
      wr(`DIC_OFF_FIQ_STATUS, 32'hFFFF_FFFF);
      rd(`DIC_OFF_IRQ_ENCLR, 32'h0000_0000);
      rd(`DIC_OFF_FIQ_SOFT, 32'h0000_0000);
      rd(12'h1FC, 32'h0000_0000);
      check_all();
      @(posedge clk);
      {inbound_post_pending, console_tx_irq, console_rx_irq} <= 3'h6;
      exp_raw = 32'h0200_0008;
      check_all();
      @(posedge clk);
      {inbound_post_pending, console_tx_irq} <= 2'h0;
      exp_raw = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         timer_expire <= 4'h1 << i;
         @(posedge clk);
         timer_expire <= 4'h0;
         exp_raw[4 + i] = 1'b1;
         check_all();
         wr(12'(`DIC_OFF_TMR1_CLR + 32 * i), 32'h0000_5A5A);
         exp_raw[4 + i] = 1'b0;
         check_all();
      end
      for (int k = 0; k < 9; k++) begin
         @(posedge clk);
         {pci_error_event, ctl_error_event, dma_done} <= 9'h001 << k;
         @(posedge clk);
         {pci_error_event, ctl_error_event, dma_done} <= 9'h000;
         exp_raw[sb[k]] = 1'b1;
         check_all();
         @(posedge clk);
         {pci_flag_clear, ctl_flag_clear, dma_flag_clear} <= 9'h001 << k;
         @(posedge clk);
         {pci_flag_clear, ctl_flag_clear, dma_flag_clear} <= 9'h000;
         exp_raw[sb[k]] = 1'b0;
         check_all();
      end
      for (int d = 0; d < 2; d++) begin
         @(posedge clk);
         host_doorbell_event <= 1'b1;
         @(posedge clk);
         host_doorbell_event <= 1'b0;
         exp_raw[15] = 1'b1;
         check_all();
         wr((d == 0) ? `DIC_OFF_DB_MASK : `DIC_OFF_DOORBELL, 32'h0000_0000);
         exp_raw[15] = 1'b0;
         check_all();
      end
      @(posedge clk);
      host_power_mgmt_ctl_status_write <= 1'b1;
      built_in_self_test_reg_start_request <= 1'b1;
      @(posedge clk);
      host_power_mgmt_ctl_status_write <= 1'b0;
      built_in_self_test_reg_start_request <= 1'b0;
      built_in_self_test_reg_reg_write <= 1'b1;
      built_in_self_test_reg_wdata_start <= 1'b1;
      @(posedge clk);
      built_in_self_test_reg_reg_write <= 1'b0;
      exp_raw = 32'h0048_0000;
      check_all();
      @(posedge clk);
      local_power_mgmt_ctl_status_write <= 1'b1;
      built_in_self_test_reg_reg_write <= 1'b1;
      built_in_self_test_reg_wdata_start <= 1'b0;
      @(posedge clk);
      local_power_mgmt_ctl_status_write <= 1'b0;
      built_in_self_test_reg_reg_write <= 1'b0;
      exp_raw = 32'h0000_0000;
      check_all();
      wr(`DIC_OFF_IRQ_SOFT, 32'h0000_0002);
      exp_raw[1] = 1'b1;
      check_all();
      wr(`DIC_OFF_FIQ_SOFT, 32'h0000_00F0);
      exp_raw[1] = 1'b0;
      check_all();
      `CHK("core entries", 1'b1, irq_taken > 8'h00 && fiq_taken > 8'h00)
      // a reset in mid-run must drop both masks again
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      irq_m = 32'h0000_0000;
      fiq_m = 32'h0000_0000;
      check_all();
      complete_run();
   end
endmodule
`default_nettype wire
